// ---- design/eisc_pkg.sv ----
// Purpose: Shared constants and types of the external request sense control.
// Assumes: 32-bit classic Wishbone register bus, 200 MHz system clock.
// Notes:   Pin n owns bits 2n+1:2n of the packed sense vector.
`default_nettype none

package eisc_pkg;

  // ****************************************************************
  // Register map and layout
  // ****************************************************************
  localparam logic [7:0]  EISC_OFS_SENSE_HIGH = 8'h00;
  localparam logic [7:0]  EISC_OFS_SENSE_LOW  = 8'h04;
  localparam logic [7:0]  EISC_OFS_FLAGS      = 8'h08;
  localparam int          EISC_FIELD_W        = 2;
  localparam int          EISC_RISE_POS       = 1;
  localparam int          EISC_FALL_POS       = 0;
  localparam int          EISC_LOW_PINS       = 8;
  localparam int          EISC_REG_W          = 16;
  localparam logic [15:0] EISC_SENSE_RESET    = 16'h0000;
  localparam logic [15:0] EISC_FLAGS_RESET    = 16'h0000;
  localparam logic        EISC_PIN_IDLE       = 1'b1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    EISC_SENSE_LOW  = 2'b00,
    EISC_SENSE_FALL = 2'b01,
    EISC_SENSE_RISE = 2'b10,
    EISC_SENSE_BOTH = 2'b11
  } eisc_sense_t;

  typedef enum logic [1:0] {
    EISC_REG_HIGH  = 2'b00,
    EISC_REG_LOW   = 2'b01,
    EISC_REG_FLAGS = 2'b10,
    EISC_REG_NONE  = 2'b11
  } eisc_reg_t;

  typedef struct packed {
    logic request;
    logic pin_high;
  } eisc_pin_stat_t;

  typedef struct packed {
    logic [7:0]  adr;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] dat;
  } eisc_wb_req_t;

endpackage : eisc_pkg

`default_nettype wire

// ---- design/eisc_pin_sense.sv ----
// Purpose: Synchronises one active-low request pin and forms its request event.
// Assumes: Pin is asynchronous to clk_i.
// Notes:   Request is a level in low sensing and a one-cycle pulse otherwise.
`default_nettype none

module eisc_pin_sense (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    pin_n_i,
  input  wire eisc_pkg::eisc_sense_t   sense_i,
  output var  eisc_pkg::eisc_pin_stat_t stat_o
);

  logic sync1_q;
  logic sync1_d;
  logic sync2_q;
  logic sync2_d;
  logic prev_q;
  logic prev_d;
  logic fall_edge;
  logic rise_edge;

  // ****************************************************************
  // Synchroniser and previous sample
  // ****************************************************************
  always_comb begin
    sync1_d = pin_n_i;
    sync2_d = sync1_q;
    prev_d  = sync2_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= eisc_pkg::EISC_PIN_IDLE;
      sync2_q <= eisc_pkg::EISC_PIN_IDLE;
      prev_q  <= eisc_pkg::EISC_PIN_IDLE;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
    end
  end

  // ****************************************************************
  // Event selection
  // ****************************************************************
  // single edge event
  assign fall_edge = prev_q & ~sync2_q;
  assign rise_edge = ~prev_q & sync2_q;

  always_comb begin
    stat_o.pin_high = sync2_q;
    unique case (sense_i)
      eisc_pkg::EISC_SENSE_LOW:  stat_o.request = ~sync2_q;
      eisc_pkg::EISC_SENSE_FALL: stat_o.request = fall_edge;
      eisc_pkg::EISC_SENSE_RISE: stat_o.request = rise_edge;
      eisc_pkg::EISC_SENSE_BOTH: stat_o.request = fall_edge | rise_edge;
    endcase
  end

endmodule : eisc_pin_sense

`default_nettype wire

// ---- design/eisc_top.sv ----
// Purpose: Sense selection and pending flags for external request pins 0 to 10.
// Assumes: Classic Wishbone slave, 32-bit data, registers in the low 16 bits.
// Notes:   Every access is answered one cycle after it is seen, unmapped ones too.
//          Flags clear by a written 0 on an enabled lane or by the handled pulse.
//          A selected event in the same cycle as a clear keeps the flag set.
//
// Overview of operation
// - Field 00 requests while pin is low.
// - Field 01 requests on falling edge.
// - Field 10 requests on rising edge.
// - Field 11 requests on both edges.
// - High register holds pins 10 to 8.
// - Low register holds pins 7 to 0.
// - Sense bits reset to zero, read/write.
// - Selected event sets the pin's flag.
// - Handling clears flag; level needs pin high.
//
// The register addresses and register access over Wishbone were left to the implementer.
`default_nettype none

module eisc_top #(
  parameter int NUM_PINS = 11
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [NUM_PINS-1:0] ext_request_pin_n_i,
  input  wire logic [NUM_PINS-1:0] request_handled_i,
  output logic      [NUM_PINS-1:0] request_pending_flag_o
);

  localparam int SENSE_W = NUM_PINS * eisc_pkg::EISC_FIELD_W;

  eisc_pkg::eisc_wb_req_t   req;
  eisc_pkg::eisc_reg_t      sel_reg;
  eisc_pkg::eisc_pin_stat_t stat     [NUM_PINS];
  eisc_pkg::eisc_sense_t    mode     [NUM_PINS];
  logic                     access;
  logic                     wr_take;
  logic [31:0]              sense_img;
  logic [31:0]              sense_new;
  logic [15:0]              flags_img;
  logic [15:0]              lane_mask;
  logic [15:0]              wr_word;
  logic [SENSE_W-1:0]       sense_q;
  logic [SENSE_W-1:0]       sense_d;
  logic [NUM_PINS-1:0]      flag_q;
  logic [NUM_PINS-1:0]      flag_d;
  logic [NUM_PINS-1:0]      sw_clear;
  logic                     ack_q;
  logic                     ack_d;
  logic [31:0]              rdat_q;
  logic [31:0]              rdat_d;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic eisc_pkg::eisc_reg_t decode_reg(input logic [7:0] adr);
    unique case (adr)
      eisc_pkg::EISC_OFS_SENSE_HIGH: decode_reg = eisc_pkg::EISC_REG_HIGH;
      eisc_pkg::EISC_OFS_SENSE_LOW:  decode_reg = eisc_pkg::EISC_REG_LOW;
      eisc_pkg::EISC_OFS_FLAGS:      decode_reg = eisc_pkg::EISC_REG_FLAGS;
      default:                       decode_reg = eisc_pkg::EISC_REG_NONE;
    endcase
  endfunction : decode_reg

  function automatic eisc_pkg::eisc_sense_t field_of(input logic [SENSE_W-1:0] vec, input int pin);
    field_of = eisc_pkg::eisc_sense_t'(vec[pin*eisc_pkg::EISC_FIELD_W +: eisc_pkg::EISC_FIELD_W]);
  endfunction : field_of

  always_comb begin
    req.adr = wb_adr_i;
    req.we  = wb_we_i;
    req.sel = wb_sel_i;
    req.dat = wb_dat_i;
  end

  assign sel_reg   = decode_reg(req.adr);
  // The registered ack blocks a second take while the answer still stands.
  assign access    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_take   = access & req.we;
  // Only byte lanes 0 and 1 carry register bits.
  assign lane_mask = {{8{req.sel[1]}}, {8{req.sel[0]}}};
  assign wr_word   = req.dat[15:0];

  // ****************************************************************
  // Register images
  // ****************************************************************
  // Pins 8 to 10 land in bits 5:0 of the upper half, and the rest reads 0.
  // low register layout
  assign sense_img = 32'(sense_q);
  assign flags_img = 16'(flag_q);

  // ****************************************************************
  // Sense select register
  // ****************************************************************
  always_comb begin
    sense_new = sense_img;
    if (wr_take && sel_reg == eisc_pkg::EISC_REG_LOW) begin
      sense_new[15:0] = (sense_img[15:0] & ~lane_mask) | (wr_word & lane_mask);
    end
    if (wr_take && sel_reg == eisc_pkg::EISC_REG_HIGH) begin
      sense_new[31:16] = (sense_img[31:16] & ~lane_mask) | (wr_word & lane_mask);
    end
    // Bits above the last pin are dropped here, so writes to them do not stick.
    sense_d = sense_new[SENSE_W-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sense_q <= SENSE_W'(32'(eisc_pkg::EISC_SENSE_RESET));
    end else begin
      sense_q <= sense_d;
    end
  end

  // ****************************************************************
  // Sense field per pin
  // ****************************************************************
  for (genvar n = 0; n < NUM_PINS; n++) begin : g_mode
    assign mode[n] = field_of(sense_q, n);
  end

  // ****************************************************************
  // Pin sensing
  // ****************************************************************
  // Each pin has its own synchroniser, so no two pins share an edge detector.
  for (genvar n = 0; n < NUM_PINS; n++) begin : g_pin
    eisc_pin_sense u_sense (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_n_i (ext_request_pin_n_i[n]),
      .sense_i (mode[n]),
      .stat_o  (stat[n])
    );
  end

  // ****************************************************************
  // Pending flags
  // ****************************************************************
  always_comb begin
    sw_clear = '0;
    // A written 0 on an enabled lane clears, and a written 1 leaves the flag alone.
    if (wr_take && sel_reg == eisc_pkg::EISC_REG_FLAGS) begin
      sw_clear = NUM_PINS'(~wr_word & lane_mask);
    end
  end

  always_comb begin
    flag_d = flag_q;
    for (int n = 0; n < NUM_PINS; n++) begin
      if (sw_clear[n]) begin
        flag_d[n] = 1'b0;
      end
      // A level request clears only once the synchronised pin is high again.
      // clear on handling
      if (request_handled_i[n]) begin
        if (mode[n] != eisc_pkg::EISC_SENSE_LOW) begin
          flag_d[n] = 1'b0;
        end else if (stat[n].pin_high) begin
          flag_d[n] = 1'b0;
        end
      end
      // The set comes last so that an event outranks a clear in the same cycle.
      // event sets flag
      if (stat[n].request) begin
        flag_d[n] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= NUM_PINS'(eisc_pkg::EISC_FLAGS_RESET);
    end else begin
      flag_q <= flag_d;
    end
  end

  assign request_pending_flag_o = flag_q;

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  always_comb begin
    // Every access, mapped or not, is answered, so a stray address cannot hang the bus.
    ack_d  = access;
    // Read data stays in place until the next access is taken.
    rdat_d = rdat_q;
    if (access) begin
      unique case (sel_reg)
        eisc_pkg::EISC_REG_HIGH:  rdat_d = {16'h0000, sense_img[31:16]};
        eisc_pkg::EISC_REG_LOW:   rdat_d = {16'h0000, sense_img[15:0]};
        eisc_pkg::EISC_REG_FLAGS: rdat_d = {16'h0000, flags_img};
        eisc_pkg::EISC_REG_NONE:  rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule : eisc_top

`default_nettype wire

// ---- sim/eisc_checker.sv ----
// Purpose: Port assertions for eisc_top.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into every eisc_top.
`default_nettype none
module eisc_checker #(
  parameter int NUM_PINS = 11
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic [NUM_PINS-1:0] ext_request_pin_n_i,
  input wire logic [NUM_PINS-1:0] request_handled_i,
  input wire logic [NUM_PINS-1:0] request_pending_flag_o
);
  // ****
  // Checks
  // ****
  logic                take_w;
  logic                clr_w;
  logic [NUM_PINS-1:0] f_q;
  assign take_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign clr_w  = take_w && wb_we_i && wb_adr_i == eisc_pkg::EISC_OFS_FLAGS;
  assign f_q    = request_pending_flag_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    take_w;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_follows: assert property (s_take |=> s_ack) else $error("ack missing");
  a_ack_needs_take: assert property (!take_w |=> !wb_ack_o) else $error("stray ack");
  a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("upper data");
  a_rdata_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("data moved");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_reset_clears: assert property (disable iff (1'b0) rst_i |=> f_q == '0 && !wb_ack_o)
    else $error("reset state");
  a_flag_cause: assert property ((f_q & ~$past(f_q) & $past(ext_request_pin_n_i, 3)
    & $past(ext_request_pin_n_i, 4)) == '0) else $error("flag without event");
  a_flag_clear: assert property (($past(f_q) & ~f_q & ~$past(request_handled_i)
    & ~$past(request_handled_i, 2) & ~($past(clr_w) ? ~$past(wb_dat_i[NUM_PINS-1:0]) : '0)) == '0)
    else $error("flag lost");
endmodule : eisc_checker
bind eisc_top eisc_checker #(.NUM_PINS(NUM_PINS)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .ext_request_pin_n_i(ext_request_pin_n_i),
  .request_handled_i(request_handled_i), .request_pending_flag_o(request_pending_flag_o));
`default_nettype wire

// ---- sim/eisc_pin_model.sv ----
// Purpose: External request pins, idle high by pull-up.
// Assumes: Levels change just after a rising edge.
// Notes:   The bench holds each level several cycles.
`default_nettype none
module eisc_pin_model #(
  parameter int NUM_PINS = 11
) (
  input  wire logic                clk_i,
  output logic      [NUM_PINS-1:0] pin_n_o
);
  initial pin_n_o = '1;
  task automatic drive(input int p, input logic v);
    @(posedge clk_i);
    pin_n_o[p] <= v;
  endtask : drive
endmodule : eisc_pin_model
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for eisc_top.
// Assumes: Wishbone answer one cycle after request.
// Notes:   Pins come from eisc_pin_model.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] H = eisc_pkg::EISC_OFS_SENSE_HIGH;
  localparam logic [7:0] L = eisc_pkg::EISC_OFS_SENSE_LOW;
  localparam logic [7:0] F = eisc_pkg::EISC_OFS_FLAGS;
  logic                  clk;
  logic                  rst;
  logic                  act;
  logic                  ack;
  eisc_pkg::eisc_wb_req_t req;
  logic [31:0]           rdat;
  logic [31:0]           rd;
  logic [3:0]            lanes;
  logic [10:0]           pin_n;
  logic [10:0]           hnd;
  logic [10:0]           flg;
  int                    errors;
  int                    checked;
  int                    pn;
  eisc_pin_model pm_u (.clk_i(clk), .pin_n_o(pin_n));
  eisc_top dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(act), .wb_stb_i(act), .wb_we_i(req.we),
    .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_request_pin_n_i(pin_n), .request_handled_i(hnd), .request_pending_flag_o(flg));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    act <= 1'b1;
    req <= '{a, w, lanes, {16'h0000, d}};
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    act <= 1'b0;
  endtask : bus
  task automatic give_verdict();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    act = 1'b0;
    req = '0;
    lanes = 4'h3;
    hnd = '0;
    errors = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, 8'(a), 16'h0000);
      check(rd, 32'h0);
    end
    bus(1'b1, L, 16'ha5c3);
    bus(1'b0, L, 16'h0000);
    check(rd, 32'h0000a5c3);
    lanes = 4'h1;
    bus(1'b1, L, 16'hffff);
    lanes = 4'h3;
    bus(1'b0, L, 16'h0000);
    check(rd, 32'h0000a5ff);
    bus(1'b1, H, 16'hffff);
    bus(1'b0, H, 16'h0000);
    check(rd, 32'h0000003f);
    bus(1'b1, 8'h0c, 16'h0000);
    bus(1'b0, H, 16'h0000);
    check(rd, 32'h0000003f);
    bus(1'b1, L, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      for (int m = 0; m < 4; m++) begin
        pn = k ? 9 : 7;
        bus(1'b1, k ? H : L, 16'(m << (k ? 2 : 14)));
        bus(1'b1, F, 16'h0000);
        pm_u.drive(pn, 1'b0);
        repeat (5) @(posedge clk);
        check(32'(flg[pn]), 32'(m != 2));
        bus(1'b1, F, 16'h0000);
        pm_u.drive(pn, 1'b1);
        repeat (5) @(posedge clk);
        check(32'(flg[pn]), 32'(m != 1));
      end
    end
    bus(1'b0, F, 16'h0000);
    check(rd, 32'h00000200);
    bus(1'b1, L, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      pm_u.drive(0, 1'(i));
      repeat (5) @(posedge clk);
      hnd <= 11'h201;
      @(posedge clk);
      hnd <= '0;
      repeat (2) @(posedge clk);
      check(32'(flg & 11'h201), 32'(i == 0));
    end
    give_verdict();
  end
endmodule : tb
`default_nettype wire
